//--- cpu_status_and_bank_regs.sv
// dedicated core registers, status word, bank and direct window address mapping
//
// How it works
// [RL1] all generated addresses are 16 bits, one 64 Kbyte linear space
// [RL2] 16-bit instruction pointer, loadable and incremented by the decoder
// [RL3] 16-bit accumulator; byte operations touch only its low byte
// [RL4] 16-bit temporary accumulator is second operand; byte ops read its low byte
// [RL5] 16-bit index register, extra pointer and stack top register
// [RL6] status word: bank and window selects high byte, condition byte low
// [RL7] direct upper half page maps to 0x0080 plus window select times 0x80
// [RL8] direct addresses 0x00 to 0x7F always map to themselves
// [RL9] window select resets to zero, unmapped; seven gives window at 0x0400
// [RL10] half carry follows carry or borrow between bit 3 and bit 4
// [RL11] interrupt enable flag gates interrupts and clears at reset
// [RL12] interrupt taken only when request level numerically below current level
// [RL13] negative flag copies result most significant bit
// [RL14] zero flag set when result is zero
// [RL15] overflow flag set on two's complement overflow
// [RL16] carry from bit 7 carry or borrow; shifts load shifted-out bit
// [RL17] byte registers, eight per bank, thirty-two banks
// [RL18] bank select plus low three opcode bits pick the register
// [RL19] bank and window selects mirrored at memory address 0x0078
// [RL20] register address is 0x0100 plus bank times eight plus index
`timescale 1ns/1ps
`include "cpu_regs_regs.svh"

module cpu_status_and_bank_regs (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // axi4-lite register port
    input wire cpu_regs_pkg::axil_req_t i_axil,
    output cpu_regs_pkg::axil_rsp_t o_axil,
    // instruction decoder side
    input wire cpu_regs_pkg::core_wr_t i_core_wr,
    input wire logic i_pc_inc,
    input wire cpu_regs_pkg::alu_req_t i_alu,
    input wire logic [7:0] i_dir_addr,
    input wire logic [2:0] i_gp_idx,
    // interrupt request
    input wire logic i_irq_req,
    input wire logic [1:0] i_irq_level,
    // data memory bus
    input wire cpu_regs_pkg::mem_req_t i_mem,
    // register contents
    output logic [15:0] o_instr_pointer,
    output logic [15:0] o_accum,
    output logic [15:0] o_temp_accum,
    output logic [15:0] o_index_reg,
    output logic [15:0] o_extra_pointer,
    output logic [15:0] o_stack_top_reg,
    output logic [15:0] o_program_status_word,
    // address mapping and interrupt results
    output logic [15:0] o_dir_phys,
    output logic [15:0] o_gp_addr,
    output logic o_irq_take,
    output logic [7:0] o_mem_rdata,
    output logic o_mem_hit
);
    import cpu_regs_pkg::*;

    state_t s_ff;
    state_t nxt_s;

    // read value of one bus register
    function automatic logic [32:0] bus_read(input state_t st, input logic [7:0] addr);
        logic [32:0] r;
        r = {1'b0, 32'h0000_0000};
        unique case (addr)
            `OFS_INSTR_POINTER: r = {1'b0, 16'h0000, st.work[SEL_IP]};
            `OFS_ACCUM: r = {1'b0, 16'h0000, st.work[SEL_ACC]};
            `OFS_TEMP_ACCUM: r = {1'b0, 16'h0000, st.work[SEL_TMP]};
            `OFS_INDEX_REG: r = {1'b0, 16'h0000, st.work[SEL_IDX]};
            `OFS_EXTRA_POINTER: r = {1'b0, 16'h0000, st.work[SEL_EXT]};
            `OFS_STACK_TOP_REG: r = {1'b0, 16'h0000, st.work[SEL_STK]};
            `OFS_PSW: r = {1'b0, 16'h0000, st.bank, st.window, st.cond};
            `OFS_XLATE_STATUS: r = {1'b0, st.gp_addr, st.dir_phys};
            default: r = {1'b1, 32'h0000_0000};
        endcase
        return r;
    endfunction

    // apply low two byte strobes to a 16-bit value
    function automatic logic [15:0] merge(input logic [15:0] old, input logic [15:0] nw,
                                          input logic [1:0] strb);
        logic [15:0] m;
        m = old;
        if (strb[0]) begin
            m[7:0] = nw[7:0];
        end
        if (strb[1]) begin
            m[15:8] = nw[15:8];
        end
        return m;
    endfunction

    // next state of the whole block
    always_comb begin
        logic [7:0] a;
        logic [7:0] b;
        logic [8:0] wide;
        logic [7:0] res;
        logic [4:0] nib;
        logic [32:0] rd;
        logic [15:0] psw;
        nxt_s = s_ff;
        a = s_ff.work[SEL_ACC][7:0]; // [RL3]
        b = s_ff.work[SEL_TMP][7:0]; // [RL4]
        wide = 9'h000;
        res = 8'h00;
        nib = 5'h00;
        rd = {1'b0, 32'h0000_0000};
        psw = 16'h0000;

        // instruction pointer step and decoder register writes
        if (i_pc_inc) begin
            nxt_s.work[SEL_IP] = s_ff.work[SEL_IP] + 16'h0001; // [RL2]
        end
        if (i_core_wr.valid) begin
            if (i_core_wr.sel == SEL_PSW) begin
                // [RL6]
                nxt_s.bank = i_core_wr.data[15:11];
                nxt_s.window = i_core_wr.data[10:8];
                nxt_s.cond = i_core_wr.data[7:0];
            end else if (i_core_wr.sel != SEL_NONE) begin
                nxt_s.work[i_core_wr.sel] = i_core_wr.data; // [RL2] [RL5]
            end
        end

        // byte alu on accumulator low bytes with flag update
        if (i_alu.valid) begin
            unique case (i_alu.op)
                ALU_ADD: begin
                    wide = {1'b0, a} + {1'b0, b};
                    nib = {1'b0, a[3:0]} + {1'b0, b[3:0]};
                    res = wide[7:0];
                    nxt_s.cond[`COND_H] = nib[4]; // [RL10]
                    nxt_s.cond[`COND_V] = (a[7] == b[7]) && (res[7] != a[7]); // [RL15]
                    nxt_s.cond[`COND_C] = wide[8]; // [RL16]
                end
                ALU_SUB: begin
                    wide = {1'b0, a} - {1'b0, b};
                    nib = {1'b0, a[3:0]} - {1'b0, b[3:0]};
                    res = wide[7:0];
                    nxt_s.cond[`COND_H] = nib[4]; // [RL10]
                    nxt_s.cond[`COND_V] = (a[7] != b[7]) && (res[7] != a[7]); // [RL15]
                    nxt_s.cond[`COND_C] = wide[8]; // [RL16]
                end
                ALU_SHL: begin
                    res = {a[6:0], 1'b0};
                    nxt_s.cond[`COND_C] = a[7]; // [RL16]
                end
                ALU_SHR: begin
                    res = {1'b0, a[7:1]};
                    nxt_s.cond[`COND_C] = a[0]; // [RL16]
                end
            endcase
            nxt_s.cond[`COND_N] = res[7]; // [RL13]
            nxt_s.cond[`COND_Z] = (res == 8'h00); // [RL14]
            nxt_s.work[SEL_ACC][7:0] = res; // [RL3]
        end

        // memory bus mirror of bank and window selects
        nxt_s.mem_hit = 1'b0;
        nxt_s.mem_rdata = 8'h00;
        if (i_mem.addr == `MIRROR_ADDR) begin
            if (i_mem.wr) begin
                nxt_s.bank = i_mem.wdata[7:3]; // [RL19]
                nxt_s.window = i_mem.wdata[2:0]; // [RL19]
                nxt_s.mem_hit = 1'b1;
            end else if (i_mem.rd) begin
                nxt_s.mem_rdata = {s_ff.bank, s_ff.window}; // [RL19]
                nxt_s.mem_hit = 1'b1;
            end
        end

        // direct address translation
        if (!i_dir_addr[7] || s_ff.window == 3'h0) begin
            nxt_s.dir_phys = {8'h00, i_dir_addr}; // [RL8] [RL9]
        end else begin
            nxt_s.dir_phys = `DIR_WIN_BASE + 16'({s_ff.window, 7'h00})
                             + 16'(i_dir_addr[6:0]); // [RL7] [RL1]
        end

        // general register address from bank select and opcode index
        nxt_s.gp_addr = `GP_BASE + 16'({s_ff.bank, 3'h0}) + 16'(i_gp_idx); // [RL17] [RL18] [RL20]

        // interrupt acceptance against enable and current level
        nxt_s.irq_take = s_ff.cond[`COND_I] && i_irq_req // [RL11]
                         && (i_irq_level < s_ff.cond[`COND_IL_HI:`COND_IL_LO]); // [RL12]

        // bus write address and data taken in either order
        if (i_axil.awvalid && s_ff.rsp.awready) begin
            nxt_s.aw_got = 1'b1;
            nxt_s.awaddr = i_axil.awaddr;
            nxt_s.rsp.awready = 1'b0;
        end
        if (i_axil.wvalid && s_ff.rsp.wready) begin
            nxt_s.w_got = 1'b1;
            nxt_s.wdata = i_axil.wdata[15:0];
            nxt_s.wstrb = i_axil.wstrb[1:0];
            nxt_s.rsp.wready = 1'b0;
        end
        if (s_ff.rsp.bvalid && i_axil.bready) begin
            nxt_s.rsp.bvalid = 1'b0;
            nxt_s.rsp.awready = 1'b1;
            nxt_s.rsp.wready = 1'b1;
        end

        // bus write, last so it wins over decoder updates in the same cycle
        if (s_ff.aw_got && s_ff.w_got && !s_ff.rsp.bvalid) begin
            nxt_s.aw_got = 1'b0;
            nxt_s.w_got = 1'b0;
            nxt_s.rsp.bvalid = 1'b1;
            nxt_s.rsp.bresp = `RESP_OKAY;
            unique case ({s_ff.awaddr[7:2], 2'h0})
                `OFS_INSTR_POINTER: begin
                    nxt_s.work[SEL_IP] = merge(nxt_s.work[SEL_IP], s_ff.wdata, s_ff.wstrb);
                end
                `OFS_ACCUM: begin
                    nxt_s.work[SEL_ACC] = merge(nxt_s.work[SEL_ACC], s_ff.wdata, s_ff.wstrb);
                end
                `OFS_TEMP_ACCUM: begin
                    nxt_s.work[SEL_TMP] = merge(nxt_s.work[SEL_TMP], s_ff.wdata, s_ff.wstrb);
                end
                `OFS_INDEX_REG: begin
                    nxt_s.work[SEL_IDX] = merge(nxt_s.work[SEL_IDX], s_ff.wdata, s_ff.wstrb);
                end
                `OFS_EXTRA_POINTER: begin
                    nxt_s.work[SEL_EXT] = merge(nxt_s.work[SEL_EXT], s_ff.wdata, s_ff.wstrb);
                end
                `OFS_STACK_TOP_REG: begin
                    nxt_s.work[SEL_STK] = merge(nxt_s.work[SEL_STK], s_ff.wdata, s_ff.wstrb);
                end
                `OFS_PSW: begin
                    psw = merge({nxt_s.bank, nxt_s.window, nxt_s.cond}, s_ff.wdata, s_ff.wstrb);
                    nxt_s.bank = psw[15:11]; // [RL6]
                    nxt_s.window = psw[10:8];
                    nxt_s.cond = psw[7:0];
                end
                `OFS_XLATE_STATUS: begin
                    nxt_s.rsp.bresp = `RESP_OKAY; // read only, write ignored
                end
                default: begin
                    nxt_s.rsp.bresp = `RESP_SLVERR;
                end
            endcase
        end

        // bus read, one outstanding
        if (s_ff.rsp.rvalid && i_axil.rready) begin
            nxt_s.rsp.rvalid = 1'b0;
            nxt_s.rsp.arready = 1'b1;
        end
        if (i_axil.arvalid && s_ff.rsp.arready) begin
            rd = bus_read(s_ff, {i_axil.araddr[7:2], 2'h0});
            nxt_s.rsp.arready = 1'b0;
            nxt_s.rsp.rvalid = 1'b1;
            nxt_s.rsp.rdata = rd[31:0];
            nxt_s.rsp.rresp = rd[32] ? `RESP_SLVERR : `RESP_OKAY;
        end
    end

    // state register
    always_ff @(posedge i_sys_clk or negedge i_arst_n) begin
        if (!i_arst_n) begin
            s_ff.work <= {6{`RST_WORK}};
            s_ff.bank <= `RST_BANK;
            s_ff.window <= `RST_WINDOW; // [RL9]
            s_ff.cond <= `RST_COND; // [RL11]
            s_ff.rsp.awready <= 1'b1;
            s_ff.rsp.wready <= 1'b1;
            s_ff.rsp.bvalid <= 1'b0;
            s_ff.rsp.bresp <= `RESP_OKAY;
            s_ff.rsp.arready <= 1'b1;
            s_ff.rsp.rvalid <= 1'b0;
            s_ff.rsp.rdata <= 32'h0000_0000;
            s_ff.rsp.rresp <= `RESP_OKAY;
            s_ff.aw_got <= 1'b0;
            s_ff.awaddr <= 8'h00;
            s_ff.w_got <= 1'b0;
            s_ff.wdata <= 16'h0000;
            s_ff.wstrb <= 2'h0;
            s_ff.dir_phys <= 16'h0000;
            s_ff.gp_addr <= `GP_BASE;
            s_ff.irq_take <= 1'b0;
            s_ff.mem_rdata <= 8'h00;
            s_ff.mem_hit <= 1'b0;
        end else begin
            s_ff <= nxt_s;
        end
    end

    // outputs straight from state flops
    assign o_axil = s_ff.rsp;
    assign o_instr_pointer = s_ff.work[SEL_IP];
    assign o_accum = s_ff.work[SEL_ACC];
    assign o_temp_accum = s_ff.work[SEL_TMP];
    assign o_index_reg = s_ff.work[SEL_IDX];
    assign o_extra_pointer = s_ff.work[SEL_EXT];
    assign o_stack_top_reg = s_ff.work[SEL_STK];
    assign o_program_status_word = {s_ff.bank, s_ff.window, s_ff.cond};
    assign o_dir_phys = s_ff.dir_phys;
    assign o_gp_addr = s_ff.gp_addr;
    assign o_irq_take = s_ff.irq_take;
    assign o_mem_rdata = s_ff.mem_rdata;
    assign o_mem_hit = s_ff.mem_hit;

endmodule

//--- cpu_regs_regs.svh
// offsets, field positions, reset values and address constants of the core registers
`ifndef CPU_REGS_REGS_SVH
`define CPU_REGS_REGS_SVH

// bus register byte offsets
`define OFS_INSTR_POINTER 8'h00
`define OFS_ACCUM 8'h04
`define OFS_TEMP_ACCUM 8'h08
`define OFS_INDEX_REG 8'h0C
`define OFS_EXTRA_POINTER 8'h10
`define OFS_STACK_TOP_REG 8'h14
`define OFS_PSW 8'h18
`define OFS_XLATE_STATUS 8'h1C

// condition byte bit positions
`define COND_H 7
`define COND_I 6
`define COND_IL_HI 5
`define COND_IL_LO 4
`define COND_N 3
`define COND_Z 2
`define COND_V 1
`define COND_C 0

// reset values
`define RST_WORK 16'h0000
`define RST_BANK 5'h00
`define RST_WINDOW 3'h0
`define RST_COND 8'h30

// memory map constants
`define MIRROR_ADDR 16'h0078
`define DIR_WIN_BASE 16'h0080
`define GP_BASE 16'h0100

// bus responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

//--- cpu_regs_pkg.sv
// types shared by the core register block and its users
package cpu_regs_pkg;

    // working register indices
    typedef enum logic [2:0] {
        SEL_IP = 3'h0,
        SEL_ACC = 3'h1,
        SEL_TMP = 3'h2,
        SEL_IDX = 3'h3,
        SEL_EXT = 3'h4,
        SEL_STK = 3'h5,
        SEL_PSW = 3'h6,
        SEL_NONE = 3'h7
    } reg_sel_t;

    // byte alu operations on the accumulator pair
    typedef enum logic [1:0] {
        ALU_ADD = 2'h0,
        ALU_SUB = 2'h1,
        ALU_SHL = 2'h2,
        ALU_SHR = 2'h3
    } alu_op_t;

    // axi4-lite master to slave
    typedef struct packed {
        logic awvalid;
        logic [7:0] awaddr;
        logic wvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [7:0] araddr;
        logic rready;
    } axil_req_t;

    // axi4-lite slave to master
    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } axil_rsp_t;

    // decoder write into a dedicated register
    typedef struct packed {
        logic valid;
        reg_sel_t sel;
        logic [15:0] data;
    } core_wr_t;

    // decoder alu request
    typedef struct packed {
        logic valid;
        alu_op_t op;
    } alu_req_t;

    // data memory bus access
    typedef struct packed {
        logic rd;
        logic wr;
        logic [15:0] addr;
        logic [7:0] wdata;
    } mem_req_t;

    // whole block state
    typedef struct packed {
        logic [5:0][15:0] work;
        logic [4:0] bank;
        logic [2:0] window;
        logic [7:0] cond;
        axil_rsp_t rsp;
        logic aw_got;
        logic [7:0] awaddr;
        logic w_got;
        logic [15:0] wdata;
        logic [1:0] wstrb;
        logic [15:0] dir_phys;
        logic [15:0] gp_addr;
        logic irq_take;
        logic [7:0] mem_rdata;
        logic mem_hit;
    } state_t;

endpackage

//--- cpu_regs_properties.sv
// concurrent checks on the core register block ports
`timescale 1ns/1ps
module cpu_regs_properties (
    // clock and reset
    input wire logic i_sys_clk,
    input wire logic i_arst_n,
    // watched inputs
    input wire cpu_regs_pkg::core_wr_t i_core_wr,
    input wire logic i_pc_inc,
    input wire cpu_regs_pkg::alu_req_t i_alu,
    input wire logic [7:0] i_dir_addr,
    input wire logic [2:0] i_gp_idx,
    input wire logic i_irq_req,
    input wire logic [1:0] i_irq_level,
    input wire cpu_regs_pkg::mem_req_t i_mem,
    // watched outputs
    input wire cpu_regs_pkg::axil_rsp_t o_axil,
    input wire logic [15:0] o_instr_pointer,
    input wire logic [15:0] o_accum,
    input wire logic [15:0] o_temp_accum,
    input wire logic [15:0] o_program_status_word,
    input wire logic [15:0] o_dir_phys,
    input wire logic [15:0] o_gp_addr,
    input wire logic o_irq_take,
    input wire logic [7:0] o_mem_rdata,
    input wire logic o_mem_hit
);
    import cpu_regs_pkg::*;
    logic [8:0] add_sum;
    logic add_h;
    logic add_v;
    logic [15:0] dir_map;
    logic [15:0] gp_exp;
    logic irq_exp;
    logic mirror_sel;
    logic [7:0] sel_byte;
    logic [7:0] acc_hi;
    // reference values built from the present state
    assign add_sum = {1'b0, o_accum[7:0]} + {1'b0, o_temp_accum[7:0]};
    assign add_h = ({1'b0, o_accum[3:0]} + {1'b0, o_temp_accum[3:0]}) > 5'h0F;
    assign add_v = (o_accum[7] == o_temp_accum[7]) && (add_sum[7] != o_accum[7]);
    assign dir_map = (!i_dir_addr[7] || o_program_status_word[10:8] == 3'h0) ? {8'h00, i_dir_addr}
        : 16'h0080 + {6'h00, o_program_status_word[10:8], 7'h00} + {9'h000, i_dir_addr[6:0]};
    assign gp_exp = 16'h0100 + {8'h00, o_program_status_word[15:11], 3'h0} + {13'h0000, i_gp_idx};
    assign irq_exp = o_program_status_word[6] && i_irq_req
        && (i_irq_level < o_program_status_word[5:4]);
    assign mirror_sel = (i_mem.rd || i_mem.wr) && i_mem.addr == 16'h0078;
    assign sel_byte = o_program_status_word[15:8];
    assign acc_hi = o_accum[15:8];

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (!i_arst_n);

    dir_window_a: assert property (o_dir_phys == $past(dir_map))
        else $error("direct address translation wrong");
    gp_address_a: assert property (o_gp_addr == $past(gp_exp))
        else $error("byte register address wrong");
    irq_gate_a: assert property (o_irq_take == $past(irq_exp))
        else $error("interrupt take wrong");
    mirror_read_a: assert property (i_mem.rd && mirror_sel |=>
        o_mem_hit && o_mem_rdata == $past(sel_byte)) else $error("mirror read wrong");
    mirror_quiet_a: assert property (!mirror_sel |=> !o_mem_hit && o_mem_rdata == 8'h00)
        else $error("memory answer without mirror access");
    add_flags_a: assert property (i_alu.valid && i_alu.op == ALU_ADD |=>
        $rose(o_axil.bvalid) || ({o_program_status_word[0], o_accum[7:0]} == $past(add_sum)
        && o_program_status_word[7] == $past(add_h) && o_program_status_word[1] == $past(add_v)))
        else $error("byte add result or flags wrong");
    nz_flags_a: assert property (i_alu.valid |=> $rose(o_axil.bvalid)
        || (o_program_status_word[3] == o_accum[7]
        && o_program_status_word[2] == (o_accum[7:0] == 8'h00))) else $error("n or z flag wrong");
    high_kept_a: assert property (i_alu.valid |=> $rose(o_axil.bvalid) || $stable(acc_hi))
        else $error("byte op touched accumulator high byte");
    ip_step_a: assert property (i_pc_inc && !i_core_wr.valid |=> $rose(o_axil.bvalid)
        || o_instr_pointer == $past(o_instr_pointer) + 16'h0001) else $error("pointer step wrong");

    // main scenarios reached
    take_c: cover property (o_irq_take);
    hit_c: cover property (o_mem_hit);
    top_window_c: cover property (o_dir_phys == 16'h047F);
endmodule

bind cpu_status_and_bank_regs cpu_regs_properties i_chk (.i_sys_clk, .i_arst_n, .i_core_wr,
    .i_pc_inc, .i_alu, .i_dir_addr, .i_gp_idx, .i_irq_req, .i_irq_level, .i_mem, .o_axil,
    .o_instr_pointer, .o_accum, .o_temp_accum, .o_program_status_word, .o_dir_phys,
    .o_gp_addr, .o_irq_take, .o_mem_rdata, .o_mem_hit);

//--- decoder_model.sv
// instruction decoder and data memory bus model
`timescale 1ns/1ps
module decoder_model (
    // clock
    input wire logic i_clk,
    // decoder and memory bus drive
    output cpu_regs_pkg::core_wr_t o_wr,
    output cpu_regs_pkg::alu_req_t o_alu,
    output cpu_regs_pkg::mem_req_t o_mem,
    output logic o_inc
);
    import cpu_regs_pkg::*;
    // idle bus at time zero
    initial begin
        o_wr = '0;
        o_alu = '0;
        o_mem = '0;
        o_inc = 1'b0;
    end
    // one-cycle register load
    task automatic put(input logic [2:0] s, input logic [15:0] d);
        @(posedge i_clk);
        o_wr <= '{1'b1, reg_sel_t'(s), d};
        @(posedge i_clk);
        o_wr <= '{1'b0, reg_sel_t'(3'h7), ~d};
        #1;
    endtask
    // one-cycle byte operation
    task automatic op(input logic [1:0] c);
        @(posedge i_clk);
        o_alu <= '{1'b1, alu_op_t'(c)};
        @(posedge i_clk);
        o_alu.valid <= 1'b0;
        #1;
    endtask
    // one memory access; released bus shows inverted lines
    task automatic acc(input logic r, input logic w, input logic [15:0] a, input logic [7:0] d);
        @(posedge i_clk);
        o_mem <= '{r, w, a, d};
        @(posedge i_clk);
        o_mem <= '{1'b0, 1'b0, ~a, ~d};
        #1;
    endtask
    // pointer step pulse
    task automatic step;
        @(posedge i_clk);
        o_inc <= 1'b1;
        @(posedge i_clk);
        o_inc <= 1'b0;
        #1;
    endtask
endmodule

//--- cpu_status_and_bank_regs_tb.sv
// self-checking bench for the core register block
`timescale 1ns/1ps
`include "cpu_regs_regs.svh"
module cpu_status_and_bank_regs_tb;
    import cpu_regs_pkg::*;
    typedef struct packed {logic [1:0] op; logic [7:0] a, t, res, flg, m;} row_t;
    logic i_sys_clk;
    logic i_arst_n;
    axil_req_t req;
    axil_rsp_t rsp;
    core_wr_t wr;
    alu_req_t alu;
    mem_req_t mem;
    logic inc, irq_req, take, hit;
    logic [1:0] lvl, resp;
    logic [7:0] dir, mrd;
    logic [2:0] gpi;
    logic [15:0] pcv, acc, tmp, idx, ext, stk, psw, phys, gpa;
    logic [31:0] rd;
    int errors, check_count, i;
    // op, a, t, result, flags under mask, mask
    row_t rows [7] = '{
        '{2'h0, 8'h0F, 8'h01, 8'h10, 8'h80, 8'h8F}, '{2'h0, 8'h80, 8'h80, 8'h00, 8'h07, 8'h8F},
        '{2'h0, 8'h7F, 8'h01, 8'h80, 8'h8A, 8'h8F}, '{2'h1, 8'h00, 8'h01, 8'hFF, 8'h89, 8'h8F},
        '{2'h1, 8'h80, 8'h01, 8'h7F, 8'h82, 8'h8F}, '{2'h2, 8'h81, 8'h00, 8'h02, 8'h01, 8'h0D},
        '{2'h3, 8'h01, 8'h00, 8'h00, 8'h05, 8'h0D}};

    cpu_status_and_bank_regs i_dut (.i_sys_clk(i_sys_clk), .i_arst_n(i_arst_n), .i_axil(req),
        .o_axil(rsp), .i_core_wr(wr), .i_pc_inc(inc), .i_alu(alu), .i_dir_addr(dir),
        .i_gp_idx(gpi), .i_irq_req(irq_req), .i_irq_level(lvl), .i_mem(mem),
        .o_instr_pointer(pcv), .o_accum(acc), .o_temp_accum(tmp), .o_index_reg(idx),
        .o_extra_pointer(ext), .o_stack_top_reg(stk), .o_program_status_word(psw),
        .o_dir_phys(phys), .o_gp_addr(gpa), .o_irq_take(take), .o_mem_rdata(mrd), .o_mem_hit(hit));
    decoder_model u_dec (.i_clk(i_sys_clk), .o_wr(wr), .o_alu(alu), .o_mem(mem), .o_inc(inc));

    // 40 MHz clock
    initial begin
        i_sys_clk = 1'b0;
        forever #12.5 i_sys_clk = ~i_sys_clk;
    end
    // compare and count
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        check_count++;
        if (s !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", n, e, s);
        end
    endtask
    // verdict and end of run
    task automatic tally_and_finish;
        if (errors == 0 && check_count > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    // axi4-lite write, address and data offered together
    task automatic axi_wr(input logic [7:0] a, input logic [15:0] d, input logic [3:0] s);
        logic ta, tw, tb;
        @(posedge i_sys_clk);
        req <= '{1'b1, a, 1'b1, {16'h0000, d}, s, 1'b1, 1'b0, 8'h00, 1'b0};
        for (int n = 0; n < 40; n++) begin
            #1;
            ta = req.awvalid && rsp.awready;
            tw = req.wvalid && rsp.wready;
            tb = req.bready && rsp.bvalid;
            resp = rsp.bresp;
            @(posedge i_sys_clk);
            if (ta) req.awvalid <= 1'b0;
            if (tw) req.wvalid <= 1'b0;
            if (tb) begin
                req.bready <= 1'b0;
                #1;
                return;
            end
        end
        chk("write timeout", 1, 0);
        tally_and_finish;
    endtask
    // axi4-lite read
    task automatic axi_rd(input logic [7:0] a);
        logic tr, tv;
        @(posedge i_sys_clk);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        for (int n = 0; n < 40; n++) begin
            #1;
            tr = req.arvalid && rsp.arready;
            tv = req.rready && rsp.rvalid;
            rd = rsp.rdata;
            resp = rsp.rresp;
            @(posedge i_sys_clk);
            if (tr) req.arvalid <= 1'b0;
            if (tv) begin
                req.rready <= 1'b0;
                #1;
                return;
            end
        end
        chk("read timeout", 1, 0);
        tally_and_finish;
    endtask
    // reset, ordinary rows, then awkward cases
    initial begin
        i_arst_n = 1'b0;
        req = '0;
        irq_req = 1'b0;
        lvl = 2'h0;
        dir = 8'h00;
        gpi = 3'h0;
        errors = 0;
        check_count = 0;
        repeat (6) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        #1;
        chk("status reset", psw, 16'h0030);
        chk("gp reset", gpa, 16'h0100);
        for (i = 0; i < 7; i++) begin
            u_dec.put(3'h1, {8'hA5, rows[i].a});
            u_dec.put(3'h2, {8'h00, rows[i].t});
            u_dec.op(rows[i].op);
            chk("alu result", acc, {8'hA5, rows[i].res});
            chk("alu flags", psw[7:0] & rows[i].m, rows[i].flg);
        end
        for (i = 0; i < 6; i++) begin
            axi_wr(8'(4 * i), 16'h1234 + 16'(i), 4'hF);
            axi_rd(8'(4 * i));
            chk("reg readback", rd, 32'h00001234 + i);
        end
        chk("temp out", tmp, 16'h1236);
        chk("index out", idx, 16'h1237);
        chk("extra out", ext, 16'h1238);
        chk("stack out", stk, 16'h1239);
        axi_wr(`OFS_ACCUM, 16'hFFFF, 4'h1);
        chk("low byte strobe", acc, 16'h12FF);
        axi_wr(`OFS_INSTR_POINTER, 16'hFFFF, 4'h3);
        u_dec.step;
        chk("pointer wrap", pcv, 16'h0000);
        axi_rd(8'h20);
        chk("unmapped resp", resp, 2'h2);
        chk("unmapped data", rd, 0);
        axi_wr(8'h20, 16'hFFFF, 4'hF);
        chk("unmapped wr resp", resp, 2'h2);
        axi_wr(`OFS_XLATE_STATUS, 16'hFFFF, 4'hF);
        chk("status wr resp", resp, 2'h0);
        axi_rd(`OFS_XLATE_STATUS);
        chk("xlate status", rd, 32'h0100_0000);
        @(posedge i_sys_clk);
        dir <= 8'hFF;
        gpi <= 3'h7;
        for (i = 0; i < 8; i++) begin
            axi_wr(`OFS_PSW, {5'(i * 3), 3'(i), 8'h30}, 4'h3);
            u_dec.acc(1'b1, 1'b0, 16'h0078, 8'h00);
            chk("mirror hit", hit, 1);
            chk("mirror byte", mrd, {5'(i * 3), 3'(i)});
            chk("direct", phys, i == 0 ? 16'h00FF : 16'h00FF + 16'(i * 128));
            chk("gp addr", gpa, 16'h0107 + 16'(i * 24));
        end
        @(posedge i_sys_clk);
        dir <= 8'h7F;
        repeat (2) @(posedge i_sys_clk);
        #1;
        chk("low direct", phys, 16'h007F);
        u_dec.acc(1'b0, 1'b1, 16'h0078, 8'h2B);
        chk("mirror write", psw[15:8], 8'h2B);
        axi_rd(`OFS_PSW);
        chk("status read", rd, 32'h0000_2B30);
        u_dec.acc(1'b1, 1'b0, 16'h0079, 8'h00);
        chk("other address", hit, 0);
        for (i = 0; i < 32; i++) begin
            u_dec.put(3'h6, {8'h00, 1'b0, i[4], i[3:2], 4'h0});
            @(posedge i_sys_clk);
            irq_req <= 1'b1;
            lvl <= i[1:0];
            repeat (2) @(posedge i_sys_clk);
            #1;
            chk("irq take", take, i[4] && (i[1:0] < i[3:2]));
        end
        @(posedge i_sys_clk);
        dir <= 8'h00;
        gpi <= 3'h0;
        irq_req <= 1'b0;
        i_arst_n <= 1'b0;
        repeat (6) @(posedge i_sys_clk);
        i_arst_n <= 1'b1;
        #1;
        chk("second reset", psw, 16'h0030);
        chk("accum reset", acc, 16'h0000);
        tally_and_finish;
    end
endmodule
